// *** shared/lpb_pkg.sv ***
package lpb_pkg;
   localparam int LPB_NB     = 8;
   localparam int LPB_BW     = 3;
   localparam int LPB_DQ_W   = 32;
   localparam int LPB_DM_W   = 4;
   localparam int LPB_CW     = 8;
   localparam int LPB_CLK_NS = 5;

   // least times in ns, rounded up to cycles below; mode register times in clocks
   localparam int LPB_T_RCD_NS  = 18;
   localparam int LPB_T_RP_NS   = 18;
   localparam int LPB_T_RRD_NS  = 10;
   localparam int LPB_T_XP_NS   = 8;
   localparam int LPB_T_RFC_NS  = 90;
   localparam int LPB_T_INIT_NS = 1000;
   localparam int LPB_T_MRR_CK  = 2;
   localparam int LPB_T_MRW_CK  = 5;
   localparam int LPB_BL        = 8;

   typedef logic [LPB_CW-1:0] lpb_cnt_t;

   localparam lpb_cnt_t LPB_ONE     = lpb_cnt_t'(1);
   localparam lpb_cnt_t LPB_RCD_LD  = lpb_cnt_t'((LPB_T_RCD_NS + LPB_CLK_NS - 1) / LPB_CLK_NS - 1);
   localparam lpb_cnt_t LPB_RP_LD   = lpb_cnt_t'((LPB_T_RP_NS + LPB_CLK_NS - 1) / LPB_CLK_NS - 1);
   localparam lpb_cnt_t LPB_RRD_LD  = lpb_cnt_t'((LPB_T_RRD_NS + LPB_CLK_NS - 1) / LPB_CLK_NS - 1);
   localparam lpb_cnt_t LPB_XP_LD   = lpb_cnt_t'((LPB_T_XP_NS + LPB_CLK_NS - 1) / LPB_CLK_NS);
   localparam lpb_cnt_t LPB_RFC_LD  = lpb_cnt_t'((LPB_T_RFC_NS + LPB_CLK_NS - 1) / LPB_CLK_NS - 1);
   localparam lpb_cnt_t LPB_INIT_LD = lpb_cnt_t'((LPB_T_INIT_NS + LPB_CLK_NS - 1) / LPB_CLK_NS - 1);
   localparam lpb_cnt_t LPB_MRR_LD  = lpb_cnt_t'(LPB_T_MRR_CK - 1);
   localparam lpb_cnt_t LPB_MRW_LD  = lpb_cnt_t'(LPB_T_MRW_CK - 1);
   localparam lpb_cnt_t LPB_BL_LD   = lpb_cnt_t'(LPB_BL - 1);

   typedef enum logic [3:0] {
      LPB_NOP, LPB_ACT, LPB_RD, LPB_WR, LPB_PRE, LPB_PREA,
      LPB_MRR, LPB_MRW, LPB_MRW_RST, LPB_BST, LPB_REFPB, LPB_REFAB
   } lpb_cmd_t;

   typedef enum logic [3:0] {
      LPB_IDLE, LPB_ROW_ACT, LPB_ACTIVE, LPB_READING, LPB_WRITING,
      LPB_RD_AP, LPB_WR_AP, LPB_PRECHG, LPB_REFRESH
   } lpb_bank_t;

   typedef enum logic [2:0] {
      LPB_POWER_ON, LPB_RESETTING, LPB_RUN, LPB_IDLE_MRR,
      LPB_ACT_MRR, LPB_RST_MRR, LPB_MR_WRITING
   } lpb_dev_t;

   // device-wide state after one effective command
   function automatic lpb_dev_t lpb_dev_next(lpb_dev_t cur, lpb_cmd_t c,
                                             logic tgt_idle, logic done);
      lpb_dev_next = cur;
      unique case (cur)
         LPB_POWER_ON: begin
            if (c == LPB_MRW_RST) lpb_dev_next = LPB_RESETTING;
         end
         LPB_RESETTING: begin
            if (c == LPB_MRR) lpb_dev_next = LPB_RST_MRR;
            else if (done) lpb_dev_next = LPB_RUN;
         end
         LPB_RUN: begin
            if (c == LPB_MRR) lpb_dev_next = tgt_idle ? LPB_IDLE_MRR : LPB_ACT_MRR;
            else if (c == LPB_MRW) lpb_dev_next = LPB_MR_WRITING;
            else if (c == LPB_MRW_RST) lpb_dev_next = LPB_RESETTING;
         end
         LPB_IDLE_MRR, LPB_ACT_MRR, LPB_RST_MRR, LPB_MR_WRITING: begin
            if (done) lpb_dev_next = LPB_RUN;
         end
      endcase
   endfunction

   function automatic lpb_cnt_t lpb_dev_load(lpb_dev_t st);
      lpb_dev_load = '0;
      unique case (st)
         LPB_RESETTING: lpb_dev_load = LPB_INIT_LD;
         LPB_IDLE_MRR, LPB_ACT_MRR, LPB_RST_MRR: lpb_dev_load = LPB_MRR_LD;
         LPB_MR_WRITING: lpb_dev_load = LPB_MRW_LD;
         LPB_POWER_ON, LPB_RUN: lpb_dev_load = '0;
      endcase
   endfunction
endpackage

// *** shared/lpb_link_if.sv ***
`timescale 1ns/100ps
interface lpb_link_if import lpb_pkg::*; ();
   logic                cke;
   lpb_cmd_t            cmd;
   logic [LPB_BW-1:0]   bank;
   logic                ap;
   logic                wvalid;
   logic [LPB_DQ_W-1:0] wdata;
   logic [LPB_DM_W-1:0] dm;

   modport ctl (output cke, output cmd, output bank, output ap,
                output wvalid, output wdata, output dm);
   modport dev (input cke, input cmd, input bank, input ap,
                input wvalid, input wdata, input dm);
endinterface

// *** src/lpb_track.sv ***
`timescale 1ns/100ps
module lpb_track import lpb_pkg::*; (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   cke,
   input  wire lpb_cmd_t               cmd,
   input  wire logic [LPB_BW-1:0]      bank,
   input  wire logic                   ap,
   output lpb_bank_t [LPB_NB-1:0]      bank_state,
   output lpb_dev_t                    dev_state,
   output logic [LPB_BW-1:0]           burst_bank,
   output logic                        ready
);
   logic              cke_prev_q;
   lpb_cnt_t          xp_q;
   logic              eff;
   lpb_cmd_t          cmd_e;
   lpb_dev_t          dev_q;
   lpb_dev_t          dev_d;
   lpb_cnt_t          dcnt_q;
   logic [LPB_BW-1:0] last_q;
   logic              run;
   logic              rw;
   lpb_bank_t         st_q [LPB_NB];

   assign eff        = cke_prev_q & cke & (xp_q == '0);
   assign cmd_e      = eff ? cmd : LPB_NOP;
   assign run        = (dev_q == LPB_RUN);
   assign rw         = run & (cmd_e inside {LPB_RD, LPB_WR});
   assign dev_d      = lpb_dev_next(dev_q, cmd_e, st_q[bank] == LPB_IDLE, dcnt_q == '0);
   assign dev_state  = dev_q;
   assign burst_bank = last_q;
   assign ready      = cke_prev_q & (xp_q == '0);

   // exit timer after a low clock enable
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cke_prev_q <= 1'b0;
         xp_q       <= '0;
      end else begin
         cke_prev_q <= cke;
         if (!cke) xp_q <= LPB_XP_LD;
         else if (xp_q != '0) xp_q <= xp_q - LPB_ONE;
      end
   end

   // device-wide state and its window timer
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dev_q  <= LPB_POWER_ON;
         dcnt_q <= '0;
      end else begin
         dev_q <= dev_d;
         if (dev_d != dev_q) dcnt_q <= lpb_dev_load(dev_d);
         else if (dcnt_q != '0) dcnt_q <= dcnt_q - LPB_ONE;
      end
   end

   // bank of the latest burst
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) last_q <= '0;
      else if (rw) last_q <= bank;
   end

   for (genvar gi = 0; gi < LPB_NB; gi++) begin : g_bank
      lpb_cmd_t bc;
      lpb_cnt_t cnt_q;
      logic     hit;
      logic     cut;

      assign hit           = (bank == LPB_BW'(gi));
      assign cut           = rw & !hit;
      assign bank_state[gi] = st_q[gi];

      always_comb begin
         bc = LPB_NOP;
         if (run) begin
            if (cmd_e == LPB_PREA) bc = LPB_PRE;
            else if (cmd_e == LPB_REFAB) bc = LPB_REFPB;
            else if (cmd_e == LPB_BST) bc = (last_q == LPB_BW'(gi)) ? LPB_BST : LPB_NOP;
            else if (hit && (cmd_e inside {LPB_ACT, LPB_RD, LPB_WR, LPB_PRE, LPB_REFPB}))
               bc = cmd_e;
         end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            st_q[gi] <= LPB_IDLE;
            cnt_q    <= '0;
         end else begin
            if (cnt_q != '0) cnt_q <= cnt_q - LPB_ONE;
            unique case (st_q[gi])
               LPB_IDLE: begin
                  if (bc == LPB_ACT) begin
                     st_q[gi] <= LPB_ROW_ACT;
                     cnt_q    <= LPB_RCD_LD;
                  end else if (bc == LPB_PRE) begin
                     st_q[gi] <= LPB_PRECHG;
                     cnt_q    <= LPB_RP_LD;
                  end else if (bc == LPB_REFPB) begin
                     st_q[gi] <= LPB_REFRESH;
                     cnt_q    <= LPB_RFC_LD;
                  end
               end
               LPB_ROW_ACT: begin
                  if (cnt_q == '0) st_q[gi] <= LPB_ACTIVE;
               end
               LPB_ACTIVE, LPB_READING, LPB_WRITING: begin
                  if (bc == LPB_RD) begin
                     st_q[gi] <= ap ? LPB_RD_AP : LPB_READING;
                     cnt_q    <= LPB_BL_LD;
                  end else if (bc == LPB_WR) begin
                     st_q[gi] <= ap ? LPB_WR_AP : LPB_WRITING;
                     cnt_q    <= LPB_BL_LD;
                  end else if (bc == LPB_PRE) begin
                     st_q[gi] <= LPB_PRECHG;
                     cnt_q    <= LPB_RP_LD;
                  end else if (bc == LPB_BST) begin
                     st_q[gi] <= LPB_ACTIVE;
                  end else if (st_q[gi] != LPB_ACTIVE && (cnt_q == '0 || cut)) begin
                     st_q[gi] <= LPB_ACTIVE;
                  end
               end
               LPB_RD_AP, LPB_WR_AP: begin
                  if (cnt_q == '0 || cut) begin
                     st_q[gi] <= LPB_PRECHG;
                     cnt_q    <= LPB_RP_LD;
                  end
               end
               LPB_PRECHG, LPB_REFRESH: begin
                  if (cnt_q == '0) st_q[gi] <= LPB_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// *** src/lpb_dev.sv ***
`timescale 1ns/100ps
module lpb_dev import lpb_pkg::*; (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   lpb_link_if.dev                     link,
   output lpb_bank_t [LPB_NB-1:0]      bank_state,
   output lpb_dev_t                    dev_state,
   output logic [LPB_BW-1:0]           burst_bank,
   output logic                        mem_we,
   output logic [LPB_BW-1:0]           mem_bank,
   output logic [LPB_DM_W-1:0]         mem_be,
   output logic [LPB_DQ_W-1:0]         mem_data
);
   logic                mem_we_q;
   logic [LPB_BW-1:0]   mem_bank_q;
   logic [LPB_DM_W-1:0] mem_be_q;
   logic [LPB_DQ_W-1:0] mem_data_q;
   logic                wr_on;

   lpb_track u_track (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .cke        (link.cke),
      .cmd        (link.cmd),
      .bank       (link.bank),
      .ap         (link.ap),
      .bank_state (bank_state),
      .dev_state  (dev_state),
      .burst_bank (burst_bank),
      .ready      ()
   );

   assign wr_on = bank_state[burst_bank] inside {LPB_WRITING, LPB_WR_AP};

   // write beats, lanes with mask high are inhibited
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_we_q   <= 1'b0;
         mem_bank_q <= '0;
         mem_be_q   <= '0;
         mem_data_q <= '0;
      end else begin
         mem_we_q   <= link.wvalid & wr_on;
         mem_bank_q <= burst_bank;
         mem_be_q   <= (link.wvalid & wr_on) ? ~link.dm : '0;
         mem_data_q <= link.wdata;
      end
   end

   assign mem_we   = mem_we_q;
   assign mem_bank = mem_bank_q;
   assign mem_be   = mem_be_q;
   assign mem_data = mem_data_q;
endmodule

// *** src/lpb_ctl.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - commands count only after exit, enable high twice
// - never issue a combination not permitted
// - bank active only after row open and tRCD
// - activate to other banks; keep tRRD between activates
// - read or write moves bank to reading/writing
// - precharge all needs every bank precharge-ready
// - mode read accepted in activating, precharging, idle, active
// - mode read destination idle or active by bank
// - burst terminate only during a burst, returns active
// - burst terminate never aimed at another bank
// - write after read needs burst end or terminate
// - read after write needs burst end or terminate
// - activate and precharge allowed during other bank bursts
// - after auto precharge, other banks free within timing
// - all-bank refresh and mode write only with all idle
// - only no-operation until mode read time ends
// - mode read ends active or all idle
// - mode write uninterruptible, then all banks idle
// - reset is a mode write, all idle, global
// - resetting device accepts mode read
// - data mask high inhibits that byte lane of the write beat
// - burst terminate hits the latest started burst
module lpb_ctl import lpb_pkg::*; (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   req_valid,
   input  wire lpb_cmd_t               req_cmd,
   input  wire logic [LPB_BW-1:0]      req_bank,
   input  wire logic                   req_ap,
   input  wire logic                   pd_req,
   input  wire logic                   wbeat_valid,
   input  wire logic [LPB_DQ_W-1:0]    wbeat_data,
   input  wire logic [LPB_DM_W-1:0]    wbeat_dm,
   lpb_link_if.ctl                     link,
   output logic                        req_done,
   output logic                        req_reject,
   output logic                        wbeat_taken,
   output lpb_dev_t                    dev_state
);
   logic                  cke_q;
   lpb_cmd_t              cmd_q;
   logic [LPB_BW-1:0]     bank_q;
   logic                  ap_q;
   logic                  wvalid_q;
   logic [LPB_DQ_W-1:0]   wdata_q;
   logic [LPB_DM_W-1:0]   dm_q;
   logic                  done_q;
   logic                  reject_q;
   lpb_cnt_t              rrd_q;

   lpb_bank_t [LPB_NB-1:0] st;
   lpb_dev_t              dev_st;
   logic [LPB_BW-1:0]     burst_bank;
   logic                  trk_ready;

   logic                  all_idle;
   logic                  any_rd;
   logic                  any_wr;
   logic                  pre_all_ok;
   logic                  mrr_ok;
   lpb_bank_t             tgt;
   logic                  ok;
   logic                  go;
   logic                  wr_on;

   // mirror of the device state, fed from the link itself
   lpb_track u_track (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .cke        (cke_q),
      .cmd        (cmd_q),
      .bank       (bank_q),
      .ap         (ap_q),
      .bank_state (st),
      .dev_state  (dev_st),
      .burst_bank (burst_bank),
      .ready      (trk_ready)
   );

   assign tgt   = st[req_bank];
   assign wr_on = st[burst_bank] inside {LPB_WRITING, LPB_WR_AP};

   // summary of all banks
   always_comb begin
      all_idle   = 1'b1;
      any_rd     = 1'b0;
      any_wr     = 1'b0;
      pre_all_ok = 1'b1;
      mrr_ok     = 1'b1;
      for (int i = 0; i < LPB_NB; i++) begin
         all_idle   &= (st[i] == LPB_IDLE);
         any_rd     |= (st[i] inside {LPB_READING, LPB_RD_AP});
         any_wr     |= (st[i] inside {LPB_WRITING, LPB_WR_AP});
         pre_all_ok &= (st[i] inside {LPB_IDLE, LPB_ACTIVE});
         mrr_ok     &= (st[i] inside {LPB_IDLE, LPB_ROW_ACT, LPB_ACTIVE, LPB_PRECHG});
      end
   end

   // permitted commands for the current mirror state
   always_comb begin
      ok = (req_cmd == LPB_NOP);
      unique case (dev_st)
         LPB_POWER_ON: begin
            if (req_cmd == LPB_MRW_RST) ok = 1'b1;
         end
         LPB_RESETTING: begin
            if (req_cmd == LPB_MRR) ok = 1'b1;
         end
         LPB_IDLE_MRR, LPB_ACT_MRR, LPB_RST_MRR, LPB_MR_WRITING: begin
            ok = (req_cmd == LPB_NOP);
         end
         LPB_RUN: begin
            unique case (req_cmd)
               LPB_NOP: begin
                  ok = 1'b1;
               end
               LPB_ACT: begin
                  ok = (tgt == LPB_IDLE) && (rrd_q == '0);
               end
               LPB_RD: begin
                  // any write burst blocks, auto precharge or not; own bank must be open
                  ok = (tgt inside {LPB_ACTIVE, LPB_READING, LPB_WRITING}) && !any_wr;
               end
               LPB_WR: begin
                  ok = (tgt inside {LPB_ACTIVE, LPB_READING, LPB_WRITING}) && !any_rd;
               end
               LPB_PRE: begin
                  ok = (tgt inside {LPB_IDLE, LPB_ACTIVE});
               end
               LPB_PREA: begin
                  ok = pre_all_ok;
               end
               LPB_MRR: begin
                  ok = mrr_ok;
               end
               LPB_MRW, LPB_REFAB: begin
                  ok = all_idle;
               end
               LPB_MRW_RST: begin
                  ok = all_idle;
               end
               LPB_REFPB: begin
                  ok = (tgt == LPB_IDLE);
               end
               LPB_BST: begin
                  ok = (req_bank == burst_bank) &&
                       (st[burst_bank] inside {LPB_READING, LPB_WRITING});
               end
            endcase
         end
      endcase
   end

   // one issued command every second cycle, only with the clock enable settled
   assign go = req_valid & (cmd_q == LPB_NOP) & cke_q & !pd_req & trk_ready;

   // clock enable follows the power-down request
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) cke_q <= 1'b0;
      else cke_q <= !pd_req;
   end

   // command issue and answer pulses
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd_q    <= LPB_NOP;
         bank_q   <= '0;
         ap_q     <= 1'b0;
         done_q   <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         cmd_q    <= LPB_NOP;
         done_q   <= 1'b0;
         reject_q <= 1'b0;
         if (go) begin
            if (ok) begin
               cmd_q  <= req_cmd;
               bank_q <= req_bank;
               ap_q   <= req_ap;
               done_q <= 1'b1;
            end else begin
               reject_q <= 1'b1;
            end
         end
      end
   end

   // spacing between activates
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) rrd_q <= '0;
      else if (go && ok && req_cmd == LPB_ACT) rrd_q <= LPB_RRD_LD;
      else if (rrd_q != '0) rrd_q <= rrd_q - LPB_ONE;
   end

   // write beats go out only while a write burst runs
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wvalid_q <= 1'b0;
         wdata_q  <= '0;
         dm_q     <= '0;
      end else begin
         wvalid_q <= wbeat_valid & wr_on;
         wdata_q  <= wbeat_data;
         dm_q     <= wbeat_dm;
      end
   end

   assign link.cke    = cke_q;
   assign link.cmd    = cmd_q;
   assign link.bank   = bank_q;
   assign link.ap     = ap_q;
   assign link.wvalid = wvalid_q;
   assign link.wdata  = wdata_q;
   assign link.dm     = dm_q;

   assign req_done    = done_q;
   assign req_reject  = reject_q;
   assign wbeat_taken = wvalid_q;
   assign dev_state   = dev_st;
endmodule

// *** bench/lpb_link_chk.sv ***
`timescale 1ns/100ps
module lpb_link_chk import lpb_pkg::*; (
   input  wire logic                sys_clk,
   input  wire logic                reset,
   input  wire logic                cke,
   input  wire lpb_cmd_t            cmd,
   input  wire logic [LPB_BW-1:0]   bank,
   input  wire logic                ap,
   input  wire logic                wvalid,
   input  wire logic [LPB_DQ_W-1:0] wdata,
   input  wire logic [LPB_DM_W-1:0] dm
);
   logic [3:0] wr_age_q;
   logic [3:0] rw_age_q;
   logic       seen_q;
   lpb_cnt_t   init_q;

   // cycles since the latest write command on the link
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) wr_age_q <= 4'hf;
      else if (cmd == LPB_WR) wr_age_q <= 4'h1;
      else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
   end

   // cycles since the latest read or write command
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) rw_age_q <= 4'hf;
      else if (cmd == LPB_RD || cmd == LPB_WR) rw_age_q <= 4'h1;
      else if (rw_age_q != 4'hf) rw_age_q <= rw_age_q + 4'h1;
   end

   // any command seen since reset
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) seen_q <= 1'b0;
      else if (cmd != LPB_NOP) seen_q <= 1'b1;
   end

   // initialization time left after a reset command
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) init_q <= '0;
      else if (cmd == LPB_MRW_RST) init_q <= LPB_INIT_LD;
      else if (cmd == LPB_MRR) init_q <= '0;
      else if (init_q != '0) init_q <= init_q - LPB_ONE;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_quiet2;
      (cmd == LPB_NOP) [*2];
   endsequence
   sequence s_quiet5;
      (cmd == LPB_NOP) [*5];
   endsequence

   a_cmd_spacing: assert property (cmd != LPB_NOP |=> cmd == LPB_NOP)
      else $error("command not followed by an idle cycle");
   a_cke_gate: assert property ((!cke || !$past(cke)) |-> cmd == LPB_NOP)
      else $error("command issued without clock enable held high");
   a_mrr_window: assert property (cmd == LPB_MRR |=> s_quiet2)
      else $error("command inside mode read window");
   a_mrw_window: assert property (cmd == LPB_MRW |=> s_quiet5)
      else $error("command inside mode write window");
   a_first_reset: assert property (!seen_q && cmd != LPB_NOP |-> cmd == LPB_MRW_RST)
      else $error("first command after power on is not a reset");
   a_init_quiet: assert property (init_q != '0 |-> cmd inside {LPB_NOP, LPB_MRR})
      else $error("command other than mode read while resetting");
   a_beat_window: assert property (wvalid |-> wr_age_q inside {[2:9]})
      else $error("write beat outside a write burst");
   a_bst_window: assert property (cmd == LPB_BST |-> rw_age_q inside {[2:9]})
      else $error("burst terminate without a running burst");
endmodule

// *** bench/lpb_bench.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h, expected %h", $time, (a), (e)); end end
module lpb_bench import lpb_pkg::*; ();
   logic                   sys_clk, reset, req_valid, req_ap, pd_req, wbeat_valid;
   logic                   req_done, req_reject, mem_we, e_ok, wtk;
   lpb_cmd_t               req_cmd;
   logic [LPB_BW-1:0]      req_bank, b1, b2, b3, mem_bank, bb;
   logic [LPB_DQ_W-1:0]    wbeat_data, mem_data;
   logic [LPB_DM_W-1:0]    wbeat_dm, mem_be;
   lpb_bank_t [LPB_NB-1:0] bs;
   lpb_dev_t               dstate, cdev;
   logic [38:0]            e_w;
   logic                   exp_ok[$];
   logic [38:0]            exp_w[$];
   int                     failures = 0;
   int                     n_compared = 0;
   int                     cycles = 0;
   integer                 seed = 32'h77abb512;

   lpb_link_if link();
   lpb_ctl lpb_ctl_i (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_ap(req_ap), .pd_req(pd_req),
      .wbeat_valid(wbeat_valid), .wbeat_data(wbeat_data), .wbeat_dm(wbeat_dm),
      .link(link.ctl), .req_done(req_done), .req_reject(req_reject),
      .wbeat_taken(wtk), .dev_state(cdev));
   lpb_dev lpb_dev_i (.sys_clk(sys_clk), .reset(reset), .link(link.dev), .bank_state(bs),
      .dev_state(dstate), .burst_bank(bb), .mem_we(mem_we), .mem_bank(mem_bank),
      .mem_be(mem_be), .mem_data(mem_data));
   lpb_link_chk lpb_link_chk_i (.sys_clk(sys_clk), .reset(reset), .cke(link.cke),
      .cmd(link.cmd), .bank(link.bank), .ap(link.ap), .wvalid(link.wvalid),
      .wdata(link.wdata), .dm(link.dm));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         give_verdict();
      end
   end

   // result watcher: answers and stored write beats
   always @(negedge sys_clk) begin
      if (req_done === 1'b1 || req_reject === 1'b1) begin
         e_ok = exp_ok.size() ? exp_ok.pop_front() : ~req_done;
         `CHK(req_done, e_ok)
      end
      if (mem_we === 1'b1) begin
         e_w = exp_w.size() ? exp_w.pop_front() : ~{mem_bank, mem_be, mem_data};
         `CHK({mem_bank, mem_be, mem_data}, e_w)
      end
   end

   task automatic idle(int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic req(lpb_cmd_t c, logic [LPB_BW-1:0] b, logic a, logic ok);
      int k;
      exp_ok.push_back(ok);
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_cmd = c;
      req_bank = b;
      req_ap = a;
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (req_done !== 1'b1 && req_reject !== 1'b1 && k < 500);
      if (k >= 500) failures++;
      req_valid = 1'b0;
   endtask

   task automatic beats(int n, logic [LPB_BW-1:0] b, bit take);
      logic [LPB_DQ_W-1:0] d;
      logic [LPB_DM_W-1:0] m;
      repeat (n) begin
         d = $random(seed);
         m = LPB_DM_W'($random(seed));
         wbeat_valid = 1'b1;
         wbeat_data = d;
         wbeat_dm = m;
         if (take) exp_w.push_back({b, ~m, d});
         @(negedge sys_clk);
         `CHK(wtk, take)
      end
      wbeat_valid = 1'b0;
   endtask

   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req_cmd = LPB_NOP;
      req_bank = '0;
      req_ap = 1'b0;
      pd_req = 1'b0;
      wbeat_valid = 1'b0;
      wbeat_data = '0;
      wbeat_dm = '0;
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      // power on, reset, mode reads
      req(LPB_MRR, 3'h0, 1'b0, 1'b0);
      req(LPB_MRW_RST, 3'h0, 1'b0, 1'b1);
      idle(1);
      `CHK(dstate, LPB_RESETTING)
      req(LPB_ACT, 3'h1, 1'b0, 1'b0);
      req(LPB_MRR, 3'h0, 1'b0, 1'b1);
      idle(1);
      `CHK(dstate, LPB_RST_MRR)
      idle(4);
      `CHK(dstate, LPB_RUN)
      `CHK(bs, {LPB_NB{LPB_IDLE}})
      req(LPB_MRR, 3'h0, 1'b0, 1'b1);
      idle(1);
      `CHK(dstate, LPB_IDLE_MRR)
      idle(3);
      $display("test power_on done");
      // inter-bank traffic
      b1 = {1'b0, 2'($random(seed))};
      b2 = b1 | 3'h4;
      b3 = b1 ^ 3'h1;
      req(LPB_ACT, b1, 1'b0, 1'b1);
      idle(1);
      `CHK(bs[b1], LPB_ROW_ACT)
      req(LPB_MRR, b1, 1'b0, 1'b1);
      idle(1);
      `CHK(dstate, LPB_ACT_MRR)
      idle(4);
      `CHK(bs[b1], LPB_ACTIVE)
      req(LPB_ACT, b2, 1'b0, 1'b1);
      idle(5);
      beats(1, b1, 1'b0);
      req(LPB_WR, b1, 1'b0, 1'b1);
      idle(1);
      beats(3, b1, 1'b1);
      `CHK(bs[b1], LPB_WRITING)
      req(LPB_RD, b2, 1'b0, 1'b0);
      req(LPB_BST, b1, 1'b0, 1'b1);
      idle(1);
      `CHK(bs[b1], LPB_ACTIVE)
      req(LPB_RD, b2, 1'b0, 1'b1);
      idle(1);
      `CHK(bs[b2], LPB_READING)
      `CHK(bb, b2)
      req(LPB_WR, b1, 1'b0, 1'b0);
      req(LPB_BST, b2, 1'b0, 1'b1);
      idle(1);
      `CHK(bs[b2], LPB_ACTIVE)
      req(LPB_RD, b2, 1'b1, 1'b1);
      idle(1);
      `CHK(bs[b2], LPB_RD_AP)
      req(LPB_ACT, b3, 1'b0, 1'b1);
      req(LPB_PRE, b1, 1'b0, 1'b1);
      idle(1);
      `CHK(bs[b1], LPB_PRECHG)
      req(LPB_REFAB, 3'h0, 1'b0, 1'b0);
      req(LPB_MRW, 3'h0, 1'b0, 1'b0);
      idle(16);
      req(LPB_PREA, 3'h0, 1'b0, 1'b1);
      idle(6);
      `CHK(bs, {LPB_NB{LPB_IDLE}})
      req(LPB_MRW, 3'h0, 1'b0, 1'b1);
      idle(1);
      `CHK(dstate, LPB_MR_WRITING)
      `CHK(cdev, LPB_MR_WRITING)
      idle(6);
      `CHK(dstate, LPB_RUN)
      $display("test interbank done");
      // clock enable low holds commands back
      pd_req = 1'b1;
      idle(3);
      `CHK(link.cke, 1'b0)
      fork
         begin
            idle(6);
            pd_req = 1'b0;
         end
      join_none
      req(LPB_ACT, b1, 1'b0, 1'b1);
      `CHK(link.cke, 1'b1)
      idle(10);
      `CHK(exp_ok.size() + exp_w.size(), 0)
      $display("test power_down done");
      give_verdict();
   end
endmodule
